// ### isf_pkg.sv
// constants, register map and types shared by the interrupt source flag block
`default_nettype none

package isf_pkg;

    // =========================================================================
    // bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int PC_W   = 13;

    // =========================================================================
    // register indices, byte address is four times the index
    localparam logic [9:0] IDX_INT_CTRL     = 10'h00b;
    localparam logic [9:0] IDX_PERIPH_FLAGS = 10'h00c;
    localparam logic [9:0] IDX_PERIPH_EN    = 10'h08c;
    localparam logic [9:0] IDX_OPTION       = 10'h081;
    localparam logic [9:0] IDX_EVT_STATUS   = 10'h090;
    localparam logic [9:0] IDX_EVT_MASK     = 10'h091;

    // =========================================================================
    // interrupt_control fields
    localparam int CTL_GLBE = 7;
    localparam int CTL_GRPE = 6;
    localparam int CTL_TMRE = 5;
    localparam int CTL_PINE = 4;
    localparam int CTL_PRTE = 3;
    localparam int CTL_TMRF = 2;
    localparam int CTL_PINF = 1;
    localparam int CTL_PRTF = 0;

    // option register: edge select of the external pin
    localparam int OPT_EDGE = 6;

    // event status / mask fields
    localparam int EVT_W    = 4;
    localparam int EVT_EXT  = 0;
    localparam int EVT_TMR  = 1;
    localparam int EVT_PORT = 2;
    localparam int EVT_WAKE = 3;

    // =========================================================================
    // reset values
    localparam logic [7:0]       CTL_RST  = 8'h00;
    localparam logic [7:0]       PF_RST   = 8'h00;
    localparam logic [7:0]       PE_RST   = 8'h00;
    localparam logic [7:0]       OPT_RST  = 8'hff;
    localparam logic [EVT_W-1:0] EVT_RST  = 4'h0;
    localparam logic [EVT_W-1:0] MASK_RST = 4'h0;

    // =========================================================================
    // timer wrap points, stack size, detector arming delay
    localparam logic [7:0] TIMER_MAX   = 8'hff;
    localparam logic [7:0] TIMER_MIN   = 8'h00;
    localparam logic [3:0] STACK_DEPTH = 4'h8;
    localparam logic [1:0] ARM_DONE    = 2'h3;

    // =========================================================================
    // types
    typedef enum logic [2:0] {
        REG_NONE, REG_CTRL, REG_PFLAG, REG_PEN, REG_OPT, REG_EVT, REG_MASK
    } isf_reg_t;

    typedef enum logic {PWR_AWAKE, PWR_ASLEEP} isf_power_t;

    // address decode shared by the read and the write path
    function automatic isf_reg_t isfRegSel(input logic [ADDR_W-1:0] addr);
        isf_reg_t sel;
        sel = REG_NONE;
        if (addr == {IDX_INT_CTRL, 2'b00})     sel = REG_CTRL;
        if (addr == {IDX_PERIPH_FLAGS, 2'b00}) sel = REG_PFLAG;
        if (addr == {IDX_PERIPH_EN, 2'b00})    sel = REG_PEN;
        if (addr == {IDX_OPTION, 2'b00})       sel = REG_OPT;
        if (addr == {IDX_EVT_STATUS, 2'b00})   sel = REG_EVT;
        if (addr == {IDX_EVT_MASK, 2'b00})     sel = REG_MASK;
        return sel;
    endfunction

endpackage

`default_nettype wire

// ### isf_return_stack.sv
// hardware return stack that keeps the program counter of taken interrupts
`timescale 1ns/1ns
`default_nettype none

module isf_return_stack
    import isf_pkg::*;
(
    input  wire logic            ref_clk,
    input  wire logic            reset_n,
    input  wire logic            pushEn,
    input  wire logic [PC_W-1:0] pushPc,
    input  wire logic            popEn,
    output logic      [PC_W-1:0] topPc,
    output logic      [3:0]      depth
);

    logic [PC_W-1:0] mem [8];
    logic [2:0]      ptr_q;
    logic [2:0]      ptr_d;
    logic [3:0]      depth_q;
    logic [3:0]      depth_d;
    logic [PC_W-1:0] top_q;
    logic [PC_W-1:0] top_d;

    // =========================================================================
    // pointer and top of stack; overflow overwrites the oldest entry silently
    always_comb begin
        ptr_d   = ptr_q;
        depth_d = depth_q;
        top_d   = top_q;
        if (pushEn) begin
            ptr_d = ptr_q + 3'h1;
            top_d = pushPc;
            if (depth_q != STACK_DEPTH) begin
                depth_d = depth_q + 4'h1;
            end
        end else if (popEn) begin
            ptr_d = ptr_q - 3'h1;
            top_d = mem[ptr_q - 3'h2];
            if (depth_q != 4'h0) begin
                depth_d = depth_q - 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ptr_q   <= 3'h0;
            depth_q <= 4'h0;
            top_q   <= '0;
        end else begin
            ptr_q   <= ptr_d;
            depth_q <= depth_d;
            top_q   <= top_d;
        end
    end

    // storage has no reset; a pop that leaves the stack empty loads an entry that was never pushed into the top
    always_ff @(posedge ref_clk) begin
        if (pushEn) begin
            mem[ptr_q] <= pushPc;
        end
    end

    assign topPc = top_q;
    assign depth = depth_q;

    AST_PUSH_PC: assert property (@(posedge ref_clk) disable iff (!reset_n)
        pushEn |=> (topPc == $past(pushPc)) && (depth != 4'h0))
        else $error("return address not on top of stack after push");

endmodule // isf_return_stack

`default_nettype wire

// ### isf_interrupt_flags.sv
// interrupt flags, enables, sleep wake and apb register file of the interrupt sources
`timescale 1ns/1ns
`default_nettype none

// Function
// - the external pin is caught on a rising edge when edge select is one and on a falling edge when zero.
// - a qualifying edge on the external pin sets the external pin flag.
// - the external pin request is held off while its enable at bit 4 of interrupt_control is clear.
// - sleep is left on an external pin event only if its enable was set before sleep began.
// - after wake the vector is taken only when the global enable is set, else execution goes on.
// - a timer-0 count wrap from ff to 00 sets the timer wrap flag.
// - the timer wrap request is passed or blocked by its enable bit.
// - any level change on the upper four port b pins sets the port change flag.
// - the port change request is passed or blocked by its enable bit.
// - taking an interrupt pushes only the return program counter onto the hardware stack.
// - flag and enable bits of an absent parallel port or serial unit are unimplemented and read zero.
// - a peripheral group request needs the group enable as well as its own enable.
module isf_interrupt_flags
    import isf_pkg::*;
#(
    parameter bit HAS_PARALLEL_PORT = 1'b1,
    parameter bit HAS_SERIAL        = 1'b1
) (
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              extIrqPin,
    input  wire logic [3:0]        portBPins,
    input  wire logic [7:0]        timer0Count,
    input  wire logic [7:0]        periphEvents,
    input  wire logic              sleepEnter,
    input  wire logic              irqAck,
    input  wire logic [PC_W-1:0]   returnPc,
    input  wire logic              irqReturn,
    output logic                   irqRequest,
    output logic                   wakeUp,
    output logic                   wakeToVector,
    output logic      [PC_W-1:0]   resumePc,
    output logic      [3:0]        stackDepth,
    output logic                   irqOut
);

    // absent units leave their flag and enable bits at zero
    localparam logic [7:0] PF_IMPL = {HAS_PARALLEL_PORT, 1'b1, HAS_SERIAL, HAS_SERIAL, 4'hf};

    // =========================================================================
    // pin synchronisers and edge detectors
    logic       extSync1_q;
    logic       extSync2_q;
    logic       extPrev_q;
    logic [3:0] portSync1_q;
    logic [3:0] portSync2_q;
    logic [3:0] portPrev_q;
    logic [7:0] tmrPrev_q;
    logic [1:0] arm_q;
    logic [1:0] arm_d;
    logic       armed;
    logic       extRise;
    logic       extFall;
    logic       extEdge;
    logic       portChange;
    logic       tmrWrap;

    // =========================================================================
    // registers and sleep state
    logic [7:0]       ctl_q;
    logic [7:0]       ctl_d;
    logic [7:0]       pf_q;
    logic [7:0]       pf_d;
    logic [7:0]       pe_q;
    logic [7:0]       pe_d;
    logic [7:0]       opt_q;
    logic [7:0]       opt_d;
    logic [EVT_W-1:0] evt_q;
    logic [EVT_W-1:0] evt_d;
    logic [EVT_W-1:0] mask_q;
    logic [EVT_W-1:0] mask_d;
    logic [7:0]       rdMux;
    logic [DATA_W-1:0] prdata_q;
    logic [DATA_W-1:0] prdata_d;
    isf_reg_t         regSel;
    logic             apbSetup;
    logic             apbAccess;
    logic             wrEn;
    logic             rdAccess;
    isf_power_t       pwr_q;
    isf_power_t       pwr_d;
    logic             pinEnAtSleep_q;
    logic             pinEnAtSleep_d;
    logic             wakeUp_q;
    logic             wakeUp_d;
    logic             vector_q;
    logic             vector_d;
    logic             wakeExt;
    logic             wakeOther;
    logic             periphPending;

    // =========================================================================
    // detectors wait a few cycles after reset so reset levels give no false edge
    always_comb begin
        arm_d = (arm_q == ARM_DONE) ? arm_q : arm_q + 2'h1;
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            extSync1_q  <= 1'b0;
            extSync2_q  <= 1'b0;
            extPrev_q   <= 1'b0;
            portSync1_q <= 4'h0;
            portSync2_q <= 4'h0;
            portPrev_q  <= 4'h0;
            tmrPrev_q   <= 8'h00;
            arm_q       <= 2'h0;
        end else begin
            extSync1_q  <= extIrqPin;
            extSync2_q  <= extSync1_q;
            extPrev_q   <= extSync2_q;
            portSync1_q <= portBPins;
            portSync2_q <= portSync1_q;
            portPrev_q  <= portSync2_q;
            tmrPrev_q   <= timer0Count; // same clock, no synchroniser
            arm_q       <= arm_d;
        end
    end

    // edge and change events, one cycle wide
    assign armed      = (arm_q == ARM_DONE);
    assign extRise    = armed & extSync2_q & ~extPrev_q;
    assign extFall    = armed & ~extSync2_q & extPrev_q;
    assign extEdge    = opt_q[OPT_EDGE] ? extRise : extFall;
    assign portChange = armed & (portSync2_q != portPrev_q);
    assign tmrWrap    = armed & (tmrPrev_q == TIMER_MAX) & (timer0Count == TIMER_MIN);

    // =========================================================================
    // apb decode; zero wait states, unmapped addresses answer with pslverr
    assign regSel    = isfRegSel(paddr);
    assign apbSetup  = psel & ~penable;
    assign apbAccess = psel & penable;
    assign wrEn      = apbAccess & pwrite;
    assign rdAccess  = apbAccess & ~pwrite;
    assign pready    = 1'b1;
    assign pslverr   = apbAccess & (regSel == REG_NONE);

    // read mux, captured during setup so prdata comes from a flop
    always_comb begin
        case (regSel)
            REG_CTRL:  rdMux = ctl_q;
            REG_PFLAG: rdMux = pf_q & PF_IMPL;
            REG_PEN:   rdMux = pe_q & PF_IMPL;
            REG_OPT:   rdMux = opt_q;
            REG_EVT:   rdMux = {4'h0, evt_q};
            REG_MASK:  rdMux = {4'h0, mask_q};
            default:   rdMux = 8'h00;
        endcase
        prdata_d = prdata_q;
        if (apbSetup && !pwrite) begin
            prdata_d = {24'h000000, rdMux};
        end
    end

    // =========================================================================
    // register next values; hardware sets come last so a set beats a clear
    always_comb begin
        ctl_d  = ctl_q;
        pf_d   = pf_q;
        pe_d   = pe_q;
        opt_d  = opt_q;
        evt_d  = evt_q;
        mask_d = mask_q;
        if (wrEn) begin
            case (regSel)
                REG_CTRL:  ctl_d  = pwdata[7:0];
                REG_PFLAG: pf_d   = pwdata[7:0] & PF_IMPL;
                REG_PEN:   pe_d   = pwdata[7:0] & PF_IMPL;
                REG_OPT:   opt_d  = pwdata[7:0];
                REG_MASK:  mask_d = pwdata[EVT_W-1:0];
                default:   ;
            endcase
        end
        // only the bits the reader actually saw are cleared
        if (rdAccess && regSel == REG_EVT) begin
            evt_d = evt_q & ~prdata_q[EVT_W-1:0];
        end
        // taking an interrupt masks further ones until the return
        if (irqAck) begin
            ctl_d[CTL_GLBE] = 1'b0;
        end else if (irqReturn) begin
            ctl_d[CTL_GLBE] = 1'b1;
        end
        if (extEdge) begin
            ctl_d[CTL_PINF] = 1'b1;
        end
        if (tmrWrap) begin
            ctl_d[CTL_TMRF] = 1'b1;
        end
        if (portChange) begin
            ctl_d[CTL_PRTF] = 1'b1;
        end
        pf_d = pf_d | (periphEvents & PF_IMPL);
        evt_d[EVT_EXT]  = evt_d[EVT_EXT] | extEdge;
        evt_d[EVT_TMR]  = evt_d[EVT_TMR] | tmrWrap;
        evt_d[EVT_PORT] = evt_d[EVT_PORT] | portChange;
        evt_d[EVT_WAKE] = evt_d[EVT_WAKE] | wakeUp_d;
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ctl_q    <= CTL_RST;
            pf_q     <= PF_RST;
            pe_q     <= PE_RST;
            opt_q    <= OPT_RST;
            evt_q    <= EVT_RST;
            mask_q   <= MASK_RST;
            prdata_q <= '0;
        end else begin
            ctl_q    <= ctl_d;
            pf_q     <= pf_d;
            pe_q     <= pe_d;
            opt_q    <= opt_d;
            evt_q    <= evt_d;
            mask_q   <= mask_d;
            prdata_q <= prdata_d;
        end
    end

    // =========================================================================
    // request to the core
    assign periphPending = ctl_q[CTL_GRPE] & |(pf_q & pe_q & PF_IMPL);
    assign irqRequest = ctl_q[CTL_GLBE] & ((ctl_q[CTL_PINE] & ctl_q[CTL_PINF])
                                         | (ctl_q[CTL_TMRE] & ctl_q[CTL_TMRF])
                                         | (ctl_q[CTL_PRTE] & ctl_q[CTL_PRTF])
                                         | periphPending);

    // =========================================================================
    // sleep and wake; the pin enable is frozen at sleep entry
    assign wakeExt   = ctl_q[CTL_PINF] & pinEnAtSleep_q;
    assign wakeOther = (ctl_q[CTL_TMRE] & ctl_q[CTL_TMRF]) | (ctl_q[CTL_PRTE] & ctl_q[CTL_PRTF]) | periphPending;

    always_comb begin
        pwr_d         = pwr_q;
        pinEnAtSleep_d = pinEnAtSleep_q;
        wakeUp_d      = 1'b0;
        vector_d      = vector_q;
        case (pwr_q)
            PWR_AWAKE: begin
                if (sleepEnter) begin
                    pwr_d         = PWR_ASLEEP;
                    pinEnAtSleep_d = ctl_q[CTL_PINE];
                end
            end
            PWR_ASLEEP: begin
                if (wakeExt || wakeOther) begin
                    pwr_d    = PWR_AWAKE;
                    wakeUp_d = 1'b1;
                    vector_d = ctl_q[CTL_GLBE];
                end
            end
            default: begin
                pwr_d = PWR_AWAKE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pwr_q         <= PWR_AWAKE;
            pinEnAtSleep_q <= 1'b0;
            wakeUp_q      <= 1'b0;
            vector_q      <= 1'b0;
        end else begin
            pwr_q         <= pwr_d;
            pinEnAtSleep_q <= pinEnAtSleep_d;
            wakeUp_q      <= wakeUp_d;
            vector_q      <= vector_d;
        end
    end

    // =========================================================================
    // outputs
    assign prdata       = prdata_q;
    assign wakeUp       = wakeUp_q;
    assign wakeToVector = vector_q;
    assign irqOut       = |(evt_q & mask_q);

    // return address push on interrupt entry
    isf_return_stack u_stack (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .pushEn  (irqAck),
        .pushPc  (returnPc),
        .popEn   (irqReturn),
        .topPc   (resumePc),
        .depth   (stackDepth)
    );

    // =========================================================================
    // assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence sqAsleepPinOnly;
        (pwr_q == PWR_ASLEEP) && !pinEnAtSleep_q && !wakeOther;
    endsequence

    sequence sqFreshRise;
        armed && !extPrev_q ##1 extSync2_q && !extPrev_q;
    endsequence

    AST_EDGE_POLARITY: assert property (
        (extRise && !opt_q[OPT_EDGE] && !(wrEn && regSel == REG_CTRL) && !ctl_q[CTL_PINF]) |=> !ctl_q[CTL_PINF])
        else $error("external flag set on the wrong edge");

    AST_EXT_FLAG_SET: assert property (
        (sqFreshRise ##0 opt_q[OPT_EDGE]) |=> ctl_q[CTL_PINF])
        else $error("rising edge did not set the external flag");

    AST_EXT_GATED: assert property (
        (ctl_q[2:0] == 3'b010 && !ctl_q[CTL_PINE] && !periphPending) |-> !irqRequest)
        else $error("disabled external source raised a request");

    AST_NO_SELF_CLEAR: assert property (
        (ctl_q[CTL_PINF] && !(wrEn && regSel == REG_CTRL)) |=> ctl_q[CTL_PINF])
        else $error("external flag cleared without a write");

    AST_SLEEP_GATE: assert property (
        sqAsleepPinOnly |=> !wakeUp_q)
        else $error("woke on a pin event whose enable was clear at sleep entry");

    AST_WAKE_VECTOR: assert property (
        wakeUp_q |-> (vector_q == $past(ctl_q[CTL_GLBE])) && ($past(pwr_q) == PWR_ASLEEP))
        else $error("wake vector choice does not follow global enable");

    AST_TIMER_WRAP: assert property (
        (armed && tmrPrev_q == TIMER_MAX && timer0Count == TIMER_MIN)
            |=> ctl_q[CTL_TMRF] ##1 (ctl_q[CTL_TMRF] || $past(wrEn && regSel == REG_CTRL)))
        else $error("timer wrap did not set its flag");

    AST_TIMER_GATE: assert property (
        (ctl_q[2:0] == 3'b100 && ctl_q[CTL_GLBE] && !periphPending) |-> (irqRequest == ctl_q[CTL_TMRE]))
        else $error("timer request does not follow its enable");

    AST_PORT_CHANGE: assert property (
        (armed && portSync2_q != portPrev_q) |=> ctl_q[CTL_PRTF])
        else $error("port change did not set its flag");

    AST_PORT_GATE: assert property (
        (ctl_q[2:0] == 3'b001 && ctl_q[CTL_GLBE] && !periphPending) |-> (irqRequest == ctl_q[CTL_PRTE]))
        else $error("port change request does not follow its enable");

    AST_ABSENT_BITS: assert property (
        ((pf_q | pe_q) & ~PF_IMPL) == 8'h00)
        else $error("unimplemented peripheral bit became set");

    AST_GROUP_GATE: assert property (
        (!ctl_q[CTL_GRPE] && ctl_q[2:0] == 3'b000) |-> !irqRequest)
        else $error("peripheral request passed with group enable clear");

    AST_GLOBAL_GATE: assert property (
        irqRequest |-> ctl_q[CTL_GLBE] ##1 (ctl_q[CTL_GLBE] || $past(irqAck) || $past(wrEn && regSel == REG_CTRL)))
        else $error("request raised with global enable clear");

endmodule // isf_interrupt_flags

`default_nettype wire

// ### isf_core_model.sv
// core sequencer model that takes interrupts offered by the flag block
`timescale 1ns/1ns
`default_nettype none

module isf_core_model
    import isf_pkg::*;
(
    input  wire logic            ref_clk,
    input  wire logic            reset_n,
    input  wire logic            takeEn,
    input  wire logic            irqRequest,
    input  wire logic [PC_W-1:0] pcBase,
    output logic                 irqAck,
    output logic      [PC_W-1:0] returnPc
);
    // =========================================================================
    // one ack per request; blocking back-to-back acks covers the cycle before global enable drops
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            irqAck   <= 1'b0;
            returnPc <= '0;
        end else begin
            irqAck   <= irqRequest & takeEn & ~irqAck;
            // address is only valid with the ack, so it holds the inverted base otherwise
            returnPc <= (irqRequest & takeEn & ~irqAck) ? pcBase : ~pcBase;
        end
    end
endmodule // isf_core_model

`default_nettype wire

// ### tb_top.sv
// self-checking bench of the interrupt source flag block
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    import isf_pkg::*;
    localparam logic [11:0] ACTL = {IDX_INT_CTRL, 2'b00};
    localparam logic [11:0] APF  = {IDX_PERIPH_FLAGS, 2'b00};
    localparam logic [11:0] APE  = {IDX_PERIPH_EN, 2'b00};
    localparam logic [11:0] AOPT = {IDX_OPTION, 2'b00};
    localparam logic [11:0] AEVT = {IDX_EVT_STATUS, 2'b00};
    localparam logic [11:0] AMSK = {IDX_EVT_MASK, 2'b00};
    logic            ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, rerr, extIrqPin;
    logic            sleepEnter, irqAck, irqReturn, irqRequest, wakeUp, wakeToVector, irqOut, takeEn;
    logic [11:0]     paddr;
    logic [31:0]     pwdata, prdata, rdata;
    logic [3:0]      portBPins, stackDepth;
    logic [7:0]      timer0Count, periphEvents;
    logic [PC_W-1:0] returnPc, resumePc;
    int              failCount, checked;

    // variant without parallel port and serial unit, so the absent bits are exercised
    isf_interrupt_flags #(.HAS_PARALLEL_PORT(1'b0), .HAS_SERIAL(1'b0))
        i_isf_interrupt_flags (.ref_clk, .reset_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .extIrqPin, .portBPins, .timer0Count, .periphEvents,
        .sleepEnter, .irqAck, .returnPc, .irqReturn, .irqRequest, .wakeUp, .wakeToVector, .resumePc,
        .stackDepth, .irqOut);
    isf_core_model i_isf_core_model (.ref_clk, .reset_n, .takeEn, .irqRequest, .pcBase(13'h1a5),
        .irqAck, .returnPc);

    // =========================================================================
    // clock and shared tasks
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failCount++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic finalReport;
        $display("checked=%0d failed=%0d", checked, failCount);
        if (failCount == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // apb transfer; request held until pready is seen at a rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            failCount++;
            finalReport();
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(exp, rdata);
    endtask
    // timer passes ff then 00, then the flag pipeline settles
    task automatic wrap;
        timer0Count <= 8'hff; tick(1);
        timer0Count <= 8'h00; tick(4);
    endtask
    task automatic waitWake(input logic vec);
        int n;
        for (n = 0; n < 20 && wakeUp !== 1'b1; n++) @(negedge ref_clk);
        chk(1, n < 20);
        chk(vec, wakeToVector);
        if (n >= 20) finalReport();
        @(posedge ref_clk);
    endtask

    // =========================================================================
    // scenarios
    task automatic tRegs;
        rd(ACTL, 32'h00); rd(AOPT, 32'hff); rd(APF, 32'h00); rd(APE, 32'h00);
        xfer(1'b0, 12'h0fc, 32'h0);
        chk(32'h1, rerr); chk(32'h0, rdata);
        wr(APE, 32'hff); rd(APE, 32'h4f); wr(APE, 32'h00);
        periphEvents <= 8'hff; tick(1); periphEvents <= 8'h00; tick(2);
        rd(APF, 32'h4f); wr(APF, 32'h00);
    endtask
    task automatic tPin;
        wr(ACTL, 32'h80); extIrqPin <= 1'b1; tick(5);
        rd(ACTL, 32'h82);
        chk(0, irqRequest);
        wr(ACTL, 32'h92); chk(1, irqRequest);
        wr(ACTL, 32'h90); extIrqPin <= 1'b0; tick(5);
        rd(ACTL, 32'h90);
        wr(AOPT, 32'hbf); extIrqPin <= 1'b1; tick(5);
        rd(ACTL, 32'h90);
        extIrqPin <= 1'b0; tick(15);
        rd(ACTL, 32'h92);
    endtask
    task automatic tTimer;
        wr(ACTL, 32'h80); timer0Count <= 8'hfe; tick(1); wrap();
        rd(ACTL, 32'h84); chk(0, irqRequest);
        wr(ACTL, 32'ha4); chk(1, irqRequest);
        wr(ACTL, 32'h00); portBPins <= 4'h8; tick(5);
        rd(ACTL, 32'h01);
        wr(ACTL, 32'h89); chk(1, irqRequest);
        wr(ACTL, 32'h00); wr(APE, 32'h01); wr(ACTL, 32'h80);
        periphEvents <= 8'h01; tick(1); periphEvents <= 8'h00; tick(2);
        rd(APF, 32'h01); chk(0, irqRequest);
        wr(ACTL, 32'hc0); chk(1, irqRequest);
        wr(APF, 32'h00); wr(ACTL, 32'h00);
    endtask
    task automatic tAck;
        wr(ACTL, 32'ha0); takeEn <= 1'b1; timer0Count <= 8'hfe; tick(1); wrap();
        takeEn <= 1'b0;
        chk(13'h1a5, resumePc); chk(1, stackDepth);
        rd(ACTL, 32'h24);
        irqReturn <= 1'b1; tick(1); irqReturn <= 1'b0; tick(1);
        chk(0, stackDepth); rd(ACTL, 32'ha4);
        wr(ACTL, 32'h00);
    endtask
    task automatic tSleep;
        sleepEnter <= 1'b1; tick(1); sleepEnter <= 1'b0;
        wr(ACTL, 32'h10); wr(AOPT, 32'hff); extIrqPin <= 1'b1; tick(2);
        repeat (8) @(negedge ref_clk) chk(0, wakeUp);
        @(posedge ref_clk);
        wr(ACTL, 32'h20); timer0Count <= 8'hff; tick(1); timer0Count <= 8'h00;
        waitWake(1'b0);
        extIrqPin <= 1'b0; wr(ACTL, 32'h90);
        sleepEnter <= 1'b1; tick(1); sleepEnter <= 1'b0;
        extIrqPin <= 1'b1; waitWake(1'b1);
        wr(ACTL, 32'h00);
    endtask
    task automatic tEvents;
        xfer(1'b0, AEVT, 32'h0); rd(AEVT, 32'h0);
        wr(AMSK, 32'h2); wrap(); chk(1, irqOut);
        rd(AEVT, 32'h2); chk(0, irqOut);
        wr(AMSK, 32'h0); wrap(); chk(0, irqOut); rd(AEVT, 32'h2);
    endtask

    // =========================================================================
    // main sequence
    initial begin
        failCount = 0; checked = 0; reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = '0; extIrqPin = 1'b0; portBPins = 4'h0; timer0Count = 8'h00;
        periphEvents = 8'h00; sleepEnter = 1'b0; irqReturn = 1'b0; takeEn = 1'b0;
        tick(6); reset_n <= 1'b1; tick(4);
        tRegs(); tPin(); tTimer(); tAck(); tSleep(); tEvents();
        finalReport();
    end
endmodule // tb_top

`default_nettype wire
